// ### src/pport_map.vh
// Register offsets, field positions and reset values of the address port
`ifndef PPORT_MAP_VH
`define PPORT_MAP_VH
`define ADDR_REG_OFFSET 4'h0
`define PIN_ENABLE_OFFSET 4'h1
`define ADDR_RESET 16'h0000
`define PIN_ENABLE_RESET 16'h0000
`define TOP_ADDR_BIT 15
`define CS1_BIT 14
`define LOW_ADDR_MSB 13
`define PIN_ENABLE_MASK 16'h47ff
`define PIN_ENABLE_MASK_SMALL 16'h4003
`endif

// ### src/pad_mux.v
// One shared pad: address function or port I/O
`timescale 1ns/100ps
module pad_mux
(
    input wire clk,
    input wire rst,
    input wire sel,
    input wire port_out,
    input wire port_oe,
    input wire func_out,
    input wire func_oe,
    output reg pad_out,
    output reg pad_oe
);
    always @(posedge clk)
    begin
        if (rst)
        begin
            pad_out <= 1'b0;
            pad_oe <= 1'b0;
        end
        else if (sel)
        begin
            pad_out <= func_out;
            pad_oe <= func_oe;
        end
        else
        begin
            // Port I/O passes untouched when not selected
            pad_out <= port_out;
            pad_oe <= port_oe;
        end
    end
endmodule // pad_mux

// ### src/parallel_port_address_pin_enable.v
// Address register, pin-enable register and pad steering of the port
//
// Design decisions made here: the register addresses and the address-and-strobe port.
`timescale 1ns/100ps
`include "pport_map.vh"
module parallel_port_address_pin_enable
#(
    parameter SMALL_VARIANT = 0
)
(
    input wire clk,
    input wire rst,
    input wire [3:0] addr,
    input wire [15:0] wdata,
    input wire wr,
    input wire rd,
    output reg [15:0] rdata,
    input wire bus_cycle,
    input wire latch_phase_en,
    input wire latch_high,
    input wire latch_low,
    input wire [15:0] port_out,
    input wire [15:0] port_oe,
    output wire [15:0] pad_out,
    output wire [15:0] pad_oe,
    output reg [15:0] address_out,
    output reg chip_select_one_strobe
);
    // Small variant has no pads for 10:2, so those enables stay clear
    localparam [15:0] EN_MASK = SMALL_VARIANT ? `PIN_ENABLE_MASK_SMALL :
        `PIN_ENABLE_MASK;
    localparam integer PAD_COUNT = 16;

    reg [15:0] parallel_destination_address_reg;
    reg [15:0] parallel_pin_function_enable_reg;
    reg [15:0] addr_line_out;
    reg [15:0] addr_line_oe;
    reg cs_pad_out;
    reg cs_pad_oe;
    reg [1:0] latch_pad_out;
    reg [1:0] latch_pad_oe;
    reg [15:0] func_out;
    reg [15:0] func_oe;
    reg [15:0] read_value;
    wire addr_hit;
    wire enable_hit;
    wire addr_write;
    wire enable_write;
    integer i;

    // Register decode for the write path; the read path decodes addr in its own case
    assign addr_hit = (addr == `ADDR_REG_OFFSET);
    assign enable_hit = (addr == `PIN_ENABLE_OFFSET);
    assign addr_write = wr & addr_hit;
    assign enable_write = wr & enable_hit;

    // Field-wise writes keep each address field on its own line
    always @(posedge clk)
    begin
        if (rst)
        begin
            parallel_destination_address_reg <= `ADDR_RESET;
        end
        else if (addr_write)
        begin
            parallel_destination_address_reg[`TOP_ADDR_BIT] <=
                wdata[`TOP_ADDR_BIT];
            parallel_destination_address_reg[`CS1_BIT] <=
                wdata[`CS1_BIT];
            parallel_destination_address_reg[`LOW_ADDR_MSB:0] <=
                wdata[`LOW_ADDR_MSB:0];
        end
    end

    // Unimplemented positions are never stored, so they always read zero
    always @(posedge clk)
    begin
        if (rst)
        begin
            parallel_pin_function_enable_reg <= `PIN_ENABLE_RESET;
        end
        else if (enable_write)
        begin
            parallel_pin_function_enable_reg[15] <= 1'b0;
            parallel_pin_function_enable_reg[`CS1_BIT] <=
                wdata[`CS1_BIT] & EN_MASK[`CS1_BIT];
            parallel_pin_function_enable_reg[13:11] <= 3'b000;
            parallel_pin_function_enable_reg[10:2] <=
                wdata[10:2] & EN_MASK[10:2];
            parallel_pin_function_enable_reg[1:0] <=
                wdata[1:0] & EN_MASK[1:0];
        end
    end

    // Unmapped indices read back zero
    always @*
    begin
        read_value = 16'h0000;
        case (addr)
            `ADDR_REG_OFFSET:
            begin
                read_value = parallel_destination_address_reg;
            end
            `PIN_ENABLE_OFFSET:
            begin
                read_value = parallel_pin_function_enable_reg;
            end
            default:
            begin
                read_value = 16'h0000;
            end
        endcase
    end

    // Read data stand for the one cycle after the strobe only
    always @(posedge clk)
    begin
        if (rst)
        begin
            rdata <= 16'h0000;
        end
        else if (rd)
        begin
            rdata <= read_value;
        end
        else
        begin
            rdata <= 16'h0000;
        end
    end

    // Registered copies lag the register by one cycle
    always @(posedge clk)
    begin
        if (rst)
        begin
            address_out <= 16'h0000;
            chip_select_one_strobe <= 1'b0;
        end
        else
        begin
            address_out <= parallel_destination_address_reg;
            chip_select_one_strobe <=
                parallel_destination_address_reg[`CS1_BIT];
        end
    end

    // Address function of every pad; driven only during a bus cycle
    always @*
    begin
        addr_line_out = 16'h0000;
        addr_line_oe = 16'h0000;
        for (i = 0; i < PAD_COUNT; i = i + 1)
        begin
            addr_line_out[i] = parallel_destination_address_reg[i];
            addr_line_oe[i] = bus_cycle;
        end
    end

    // Pad fourteen carries the chip select level and, while its enable bit is set,
    // is driven at all times, so the peripheral never sees a floating select
    always @*
    begin
        cs_pad_out = parallel_destination_address_reg[`CS1_BIT];
        cs_pad_oe = 1'b1;
    end

    // Latch strobes take pads 1:0 over from the address bits
    always @*
    begin
        if (latch_phase_en)
        begin
            latch_pad_out = {latch_high, latch_low};
            latch_pad_oe = 2'b11;
        end
        else
        begin
            latch_pad_out = addr_line_out[1:0];
            latch_pad_oe = addr_line_oe[1:0];
        end
    end

    // Merge the three pad groups into one function vector
    always @*
    begin
        func_out = addr_line_out;
        func_oe = addr_line_oe;
        func_out[`CS1_BIT] = cs_pad_out;
        func_oe[`CS1_BIT] = cs_pad_oe;
        func_out[1:0] = latch_pad_out;
        func_oe[1:0] = latch_pad_oe;
    end

    // Each pad is registered, so pads lag their inputs by one cycle;
    // this keeps every pad output glitch free at the cost of latency.
    // Pads whose enable bit is clear pass port I/O untouched.
    genvar g;
    generate
        for (g = 0; g < 16; g = g + 1)
        begin : pads
            pad_mux u_pad
            (
                .clk(clk),
                .rst(rst),
                .sel(parallel_pin_function_enable_reg[g]),
                .port_out(port_out[g]),
                .port_oe(port_oe[g]),
                .func_out(func_out[g]),
                .func_oe(func_oe[g]),
                .pad_out(pad_out[g]),
                .pad_oe(pad_oe[g])
            );
        end
    endgenerate
endmodule // parallel_port_address_pin_enable

// ### test/pport_partner.sv
// Far-side peripheral: samples pads, pull-up on undriven pads
`timescale 1ns/100ps
module pport_partner(input wire clk,input wire [15:0] pad_out,pad_oe,
output reg [15:0] seen);
always @(posedge clk)seen<=pad_out&pad_oe|~pad_oe;
endmodule // pport_partner

// ### test/pport_chk_checker.sv
// Port checker
`timescale 1ns/100ps
module pport_chk #(parameter SMALL_VARIANT=0)
(input wire clk,rst,wr,rd,bus_cycle,latch_phase_en,latch_low,
input wire chip_select_one_strobe,input wire [3:0] addr,
input wire [15:0] wdata,rdata,pad_out,address_out,port_out);
localparam [15:0] MASK=SMALL_VARIANT?16'h4003:16'h47ff;
wire b=bus_cycle;
wire [15:0] q=pad_out,o=address_out;
reg [15:0] e_reg;
// Mirror of the enable register, kept so pad checks know each pad's role
always @(posedge clk)e_reg<=rst?16'h0000:wr&&addr==1?wdata&MASK:e_reg;
default clocking @(posedge clk);endclocking
default disable iff(rst);
property p_a;wr&&addr==0 ##1 rd&&addr==0|=>rdata==$past(wdata,2);endproperty
a_a:assert property(p_a)else $error("addr");
property p_c;wr&&addr==0|=>##1 chip_select_one_strobe==$past(wdata[14],2);
endproperty
a_c:assert property(p_c)else $error("cs");
property p_m;$past(e_reg[5]&b)|->q[5]==o[5];endproperty
a_m:assert property(p_m)else $error("pad");
property p_l;$past(e_reg[0]&b&latch_phase_en)|->q[0]==$past(latch_low);
endproperty
a_l:assert property(p_l)else $error("latch");
property p_u;rd&&addr==1|=>(rdata&16'hb800)==0;endproperty
a_u:assert property(p_u)else $error("unimpl");
property p_p;!$past(rst)&&$past(!e_reg[12])|->q[12]==$past(port_out[12]);
endproperty
a_p:assert property(p_p)else $error("port");
endmodule // pport_chk
bind parallel_port_address_pin_enable pport_chk
#(.SMALL_VARIANT(SMALL_VARIANT)) pport_chk_i(.*);

// ### test/parallel_port_address_pin_enable_tb.sv
// Port bench
`timescale 1ns/100ps
module parallel_port_address_pin_enable_tb;
reg clk=0,rst=1,wr=0,rd=0,bus_cycle=0,latch_phase_en=0;
reg latch_high=1,latch_low=0;
reg [3:0] addr=0;
reg [15:0] wdata=0,port_out=16'h3a5c,port_oe=16'hffff;
wire [15:0] rdata,pad_out,pad_oe,address_out,seen;
wire chip_select_one_strobe;
wire [15:0] rdata_s,pad_out_s;
integer fails=0,checks_done=0,n=0;
parallel_port_address_pin_enable parallel_port_address_pin_enable_i(.*);
pport_partner pport_partner_i(.*);
parallel_port_address_pin_enable #(.SMALL_VARIANT(1))
parallel_port_address_pin_enable_small_i(.clk,.rst,.addr,.wdata,.wr,.rd,
.rdata(rdata_s),.bus_cycle,.latch_phase_en,.latch_high,.latch_low,.port_out,
.port_oe,.pad_out(pad_out_s),.pad_oe(),.address_out(),
.chip_select_one_strobe());
always #2 clk=~clk;
always @(posedge clk)if(++n>999)begin fails++;close_out;end
task chk(input logic [15:0] s,e);
checks_done++;
if(s!==e)begin fails++;$display("unexpected %0t %h",$time,s);end
endtask
task wreg(input logic [3:0] a,input logic [15:0] d);
addr<=a;wdata<=d;wr<=1;rd<=0;@(posedge clk);
endtask
// Read data stand one cycle only, so look mid-cycle
task rreg(input logic [3:0] a,input logic [15:0] e);
addr<=a;wr<=0;rd<=1;@(posedge clk)rd<=0;
@(negedge clk)chk(rdata,e);@(posedge clk);
endtask
task close_out;
$display("checks %0d fails %0d",checks_done,fails);
if(fails==0&&checks_done>0)$display("TEST PASSED");
else $display("TEST FAILED");
$finish;
endtask
task t_regs;
rreg(1,0);
wreg(1,16'hffff);rreg(1,16'h47ff);
wreg(0,16'hc5a3);rreg(0,16'hc5a3);
$display("t_regs done");
endtask
task t_pads;
bus_cycle<=1;repeat(3)@(posedge clk);
chk(seen,port_out&16'hb800|16'hc5a3&16'h47ff);
latch_phase_en<=1;repeat(3)@(posedge clk);
chk(seen&3,2);
wreg(1,0);wr<=0;repeat(3)@(posedge clk);
chk(seen,port_out);
$display("t_pads done");
endtask
task t_small;
wreg(1,16'hffff);addr<=1;wr<=0;rd<=1;@(posedge clk)rd<=0;
@(negedge clk)chk(rdata_s,16'h4003);
chk(rdata,16'h47ff);
@(posedge clk);
chk(pad_out_s&16'h07fc,port_out&16'h07fc);
chk(pad_out&16'h07fc,16'hc5a3&16'h07fc);
$display("t_small done");
endtask
initial begin repeat(5)@(posedge clk);rst<=0;t_regs;t_pads;t_small;close_out;end
endmodule // parallel_port_address_pin_enable_tb
